// ===== inc/pdm_pkg.sv
/*
  Constants for the port pin drive mode block: register addresses, reset values and the
  2-bit pin code meanings.
  Assumes a byte-addressed register port with 16-bit data lanes.
*/
package pdm_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [15:0] PDM_ADDR_DATA     = 16'hF258;
    localparam logic [15:0] PDM_ADDR_DIR      = 16'hF259;
    localparam logic [15:0] PDM_ADDR_SEL_LOW  = 16'hF25A;
    localparam logic [15:0] PDM_ADDR_SEL_HIGH = 16'hF25B;

    localparam logic [7:0]  PDM_RESET_BYTE    = 8'h00;
    localparam logic [7:0]  PDM_DIR_OUTPUT    = 8'h00;
    localparam logic [15:0] PDM_RDATA_IDLE    = 16'h0000;
    localparam int          PDM_PINS          = 8;

    // ----------------------------------------------------------------
    // Pin codes
    // ----------------------------------------------------------------
    localparam logic [1:0] PDM_CODE_HIZ  = 2'h0;
    localparam logic [1:0] PDM_CODE_PCH  = 2'h1;
    localparam logic [1:0] PDM_CODE_NCH  = 2'h2;
    localparam logic [1:0] PDM_CODE_CMOS = 2'h3;

    localparam logic       PDM_DIR_OUT_BIT = 1'b0;

endpackage : pdm_pkg

// ===== hdl/pdm_sync.sv
/*
  Two-flop synchroniser for the pin input levels.
  Assumes the pins are asynchronous to ref_clk_in.
*/
`timescale 1ns/100ps
module pdm_sync
    import pdm_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_in,
    input  wire logic                reset_n_in,
    // Data
    input  wire logic [PDM_PINS-1:0] async_in,
    output logic      [PDM_PINS-1:0] sync_out
);

    logic [PDM_PINS-1:0] stage1_r;
    logic [PDM_PINS-1:0] stage2_r;
    logic [PDM_PINS-1:0] stage1_nxt;
    logic [PDM_PINS-1:0] stage2_nxt;

    always_comb
    begin
        stage1_nxt = async_in;
        stage2_nxt = stage1_r;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            stage1_r <= PDM_RESET_BYTE;
            stage2_r <= PDM_RESET_BYTE;
        end
        else
        begin
            stage1_r <= stage1_nxt;
            stage2_r <= stage2_nxt;
        end
    end

    assign sync_out = stage2_r;

endmodule : pdm_sync

// ===== hdl/pdm_pin_drv.sv
/*
  Decode of one pin: direction bit, 2-bit code and data bit into driver controls.
  Pure combinational; the top registers the results.
*/
`timescale 1ns/100ps
module pdm_pin_drv
    import pdm_pkg::*;
(
    // Control
    input  wire logic       dir_in,
    input  wire logic [1:0] code_in,
    input  wire logic       data_in,
    // Pad controls
    output logic            pad_out,
    output logic            pad_oe_n_out,
    output logic            pull_up_out,
    output logic            pull_down_out
);

    always_comb
    begin
        pad_out       = 1'b0;
        pad_oe_n_out  = 1'b1;
        pull_up_out   = 1'b0;
        pull_down_out = 1'b0;
        if (dir_in == PDM_DIR_OUT_BIT) // [RL3]
        begin
            case (code_in) // [RL1]
                PDM_CODE_PCH:
                begin
                    pad_out      = 1'b1;
                    pad_oe_n_out = ~data_in; // [RL7]
                end
                PDM_CODE_NCH:
                begin
                    pad_out      = 1'b0;
                    pad_oe_n_out = data_in; // [RL7]
                end
                PDM_CODE_CMOS:
                begin
                    pad_out      = data_in; // [RL7]
                    pad_oe_n_out = 1'b0;
                end
                default:
                begin
                    pad_oe_n_out = 1'b1;
                end
            endcase
        end
        else
        begin
            case (code_in) // [RL2]
                PDM_CODE_PCH:  pull_down_out = 1'b1;
                PDM_CODE_NCH:  pull_up_out   = 1'b1;
                default:       pull_up_out   = 1'b0;
            endcase
        end
    end

endmodule : pdm_pin_drv

// ===== hdl/pdm_port_drive.sv
/*
  Eight-pin general-purpose port with per-pin drive mode selection.
  Holds data, direction and the two drive-select registers, decodes each pin
  and registers all pad controls.
  Assumes a register port whose read data appear one cycle after the read
  strobe, and an external pad that resolves level from output and enable.
*/
// Implementation choice: strobed register access.
// Notes on behaviour
// RL1 - Output mode codes: 00 hi-Z, 01 P open drain, 10 N open drain, 11 CMOS.
// RL2 - Input mode codes: 00 hi-Z, 01 pull-down, 10 pull-up, 11 hi-Z.
// RL3 - Direction bit 0 picks output meanings, 1 picks input meanings.
// RL4 - Low select register gives code bit 0, high register gives code bit 1.
// RL5 - Both select registers clear at reset, so pins start hi-Z output.
// RL6 - Select registers at F25A and F25B, fully read/write, byte or word.
// RL7 - Output mode drives data bit; input mode data read returns pin level.
// RL8 - Direction bits clear at reset, every pin starts as output.
// RL9 - Word access at F25A: low byte low register, high byte high register.
`timescale 1ns/100ps
module pdm_port_drive
    import pdm_pkg::*;
(
    // Clock and reset
    input  wire logic                ref_clk_in,
    input  wire logic                reset_n_in,
    // Register port
    input  wire logic [15:0]         reg_addr_in,
    input  wire logic [15:0]         reg_wdata_in,
    input  wire logic                reg_word_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    output logic      [15:0]         reg_rdata_out,
    // Pins
    input  wire logic [PDM_PINS-1:0] pin_in,
    output logic      [PDM_PINS-1:0] pin_out,
    output logic      [PDM_PINS-1:0] pin_oe_n_out,
    output logic      [PDM_PINS-1:0] pull_up_out,
    output logic      [PDM_PINS-1:0] pull_down_out
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0]          port_data_register_r;
    logic [7:0]          port_direction_register_r;
    logic [7:0]          pin_drive_select_low_r;
    logic [7:0]          pin_drive_select_high_r;
    logic [15:0]         rdata_r;
    logic [7:0]          data_nxt;
    logic [7:0]          dir_nxt;
    logic [7:0]          sel_low_nxt;
    logic [7:0]          sel_high_nxt;
    logic [15:0]         rdata_nxt;
    logic [PDM_PINS-1:0] pin_sync;
    logic                word_low;

    pdm_sync u_sync
    (
        .clk_in     (ref_clk_in),
        .reset_n_in (reset_n_in),
        .async_in   (pin_in),
        .sync_out   (pin_sync)
    );

    // Word access only at the low select address; elsewhere it acts as a byte
    assign word_low = reg_word_in && (reg_addr_in == PDM_ADDR_SEL_LOW);

    always_comb
    begin
        data_nxt     = port_data_register_r;
        dir_nxt      = port_direction_register_r;
        sel_low_nxt  = pin_drive_select_low_r;
        sel_high_nxt = pin_drive_select_high_r;
        rdata_nxt    = PDM_RDATA_IDLE;
        if (reg_wr_in)
        begin
            case (reg_addr_in)
                PDM_ADDR_DATA:     data_nxt     = reg_wdata_in[7:0];
                PDM_ADDR_DIR:      dir_nxt      = reg_wdata_in[7:0];
                PDM_ADDR_SEL_LOW:
                begin
                    sel_low_nxt = reg_wdata_in[7:0]; // [RL6]
                    if (word_low)
                    begin
                        sel_high_nxt = reg_wdata_in[15:8]; // [RL9]
                    end
                end
                PDM_ADDR_SEL_HIGH: sel_high_nxt = reg_wdata_in[7:0]; // [RL6]
                default:           data_nxt     = port_data_register_r;
            endcase
        end
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                // Input pins read live level, output pins the stored bit
                PDM_ADDR_DATA:
                    rdata_nxt = {8'h00, (port_direction_register_r & pin_sync)
                                 | (~port_direction_register_r & port_data_register_r)}; // [RL7]
                PDM_ADDR_DIR:      rdata_nxt = {8'h00, port_direction_register_r};
                PDM_ADDR_SEL_LOW:
                    rdata_nxt = word_low
                              ? {pin_drive_select_high_r, pin_drive_select_low_r} // [RL9]
                              : {8'h00, pin_drive_select_low_r}; // [RL6]
                PDM_ADDR_SEL_HIGH: rdata_nxt = {8'h00, pin_drive_select_high_r}; // [RL6]
                default:           rdata_nxt = PDM_RDATA_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            port_data_register_r      <= PDM_RESET_BYTE;
            port_direction_register_r <= PDM_DIR_OUTPUT; // [RL8]
            pin_drive_select_low_r    <= PDM_RESET_BYTE; // [RL5]
            pin_drive_select_high_r   <= PDM_RESET_BYTE; // [RL5]
            rdata_r                   <= PDM_RDATA_IDLE;
        end
        else
        begin
            port_data_register_r      <= data_nxt;
            port_direction_register_r <= dir_nxt;
            pin_drive_select_low_r    <= sel_low_nxt;
            pin_drive_select_high_r   <= sel_high_nxt;
            rdata_r                   <= rdata_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;

    // ----------------------------------------------------------------
    // Pin decode
    // ----------------------------------------------------------------
    logic [PDM_PINS-1:0] pad_nxt;
    logic [PDM_PINS-1:0] oe_n_nxt;
    logic [PDM_PINS-1:0] pu_nxt;
    logic [PDM_PINS-1:0] pd_nxt;
    logic [PDM_PINS-1:0] pad_r;
    logic [PDM_PINS-1:0] oe_n_r;
    logic [PDM_PINS-1:0] pu_r;
    logic [PDM_PINS-1:0] pd_r;

    genvar gi;
    generate
        for (gi = 0; gi < PDM_PINS; gi++)
        begin : g_pin
            pdm_pin_drv u_drv
            (
                .dir_in        (port_direction_register_r[gi]),
                .code_in       ({pin_drive_select_high_r[gi],
                                 pin_drive_select_low_r[gi]}), // [RL4]
                .data_in       (port_data_register_r[gi]),
                .pad_out       (pad_nxt[gi]),
                .pad_oe_n_out  (oe_n_nxt[gi]),
                .pull_up_out   (pu_nxt[gi]),
                .pull_down_out (pd_nxt[gi])
            );
        end
    endgenerate

    // Registered pad controls cost one cycle of latency but keep outputs glitch free
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pad_r  <= PDM_RESET_BYTE;
            oe_n_r <= ~PDM_RESET_BYTE;
            pu_r   <= PDM_RESET_BYTE;
            pd_r   <= PDM_RESET_BYTE;
        end
        else
        begin
            pad_r  <= pad_nxt;
            oe_n_r <= oe_n_nxt;
            pu_r   <= pu_nxt;
            pd_r   <= pd_nxt;
        end
    end

    assign pin_out       = pad_r;
    assign pin_oe_n_out  = oe_n_r;
    assign pull_up_out   = pu_r;
    assign pull_down_out = pd_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_cmos_out(int i);
        port_direction_register_r[i] == 1'b0
        && pin_drive_select_high_r[i] && pin_drive_select_low_r[i];
    endsequence

    property p_cmos_drive;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        s_cmos_out(0) |=> (!pin_oe_n_out[0] && pin_out[0] == $past(port_data_register_r[0]));
    endproperty
    a_cmos_drive: assert property (p_cmos_drive) else $error("cmos pin not driving data"); // [RL1]

    property p_hiz_out;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (port_direction_register_r == 8'h00 && pin_drive_select_low_r == 8'h00
         && pin_drive_select_high_r == 8'h00) |=> (pin_oe_n_out == 8'hFF);
    endproperty
    a_hiz_out: assert property (p_hiz_out) else $error("hi-Z code drives pin"); // [RL5]

    property p_nch;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (!port_direction_register_r[1] && pin_drive_select_high_r[1]
         && !pin_drive_select_low_r[1]) |=> (pin_out[1] == 1'b0
         && pin_oe_n_out[1] == $past(port_data_register_r[1]));
    endproperty
    a_nch: assert property (p_nch) else $error("n open drain wrong"); // [RL1]

    property p_pull_up;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (port_direction_register_r[2] && pin_drive_select_high_r[2]
         && !pin_drive_select_low_r[2]) |=> (pull_up_out[2] && !pull_down_out[2]
         && pin_oe_n_out[2]);
    endproperty
    a_pull_up: assert property (p_pull_up) else $error("pull-up not selected"); // [RL2]

    property p_input_no_drive;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        port_direction_register_r[3] |=> pin_oe_n_out[3];
    endproperty
    a_input_no_drive: assert property (p_input_no_drive) else $error("input pin driven"); // [RL3]

    property p_word_write;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (reg_wr_in && reg_word_in && reg_addr_in == PDM_ADDR_SEL_LOW)
        |=> (pin_drive_select_high_r == $past(reg_wdata_in[15:8])
             && pin_drive_select_low_r == $past(reg_wdata_in[7:0]));
    endproperty
    a_word_write: assert property (p_word_write) else $error("word write lost"); // [RL9]

    property p_readback;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (reg_rd_in && !reg_word_in && reg_addr_in == PDM_ADDR_SEL_HIGH)
        |=> (reg_rdata_out == {8'h00, $past(pin_drive_select_high_r)});
    endproperty
    a_readback: assert property (p_readback) else $error("high select readback wrong"); // [RL6]

    property p_code_bits;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (port_direction_register_r[4] && !pin_drive_select_high_r[4]
         && pin_drive_select_low_r[4]) |=> pull_down_out[4];
    endproperty
    a_code_bits: assert property (p_code_bits) else $error("code bit order wrong"); // [RL4]

    property p_data_read;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (reg_rd_in && reg_addr_in == PDM_ADDR_DATA && port_direction_register_r[5])
        |=> (reg_rdata_out[5] == $past(pin_sync[5]));
    endproperty
    a_data_read: assert property (p_data_read) else $error("input level not read"); // [RL7]

    property p_pch_drive;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (!port_direction_register_r[6] && !pin_drive_select_high_r[6]
         && pin_drive_select_low_r[6]) |=> (pin_out[6]
         && pin_oe_n_out[6] == !$past(port_data_register_r[6]));
    endproperty
    a_pch_drive: assert property (p_pch_drive) else $error("p open drain wrong"); // [RL1]

    property p_input_hiz;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (port_direction_register_r[7] && pin_drive_select_high_r[7]
         && pin_drive_select_low_r[7]) |=> (pin_oe_n_out[7] && !pull_up_out[7]
         && !pull_down_out[7]);
    endproperty
    a_input_hiz: assert property (p_input_hiz) else $error("input code 11 not hi-Z"); // [RL2]

    property p_rdata_idle;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        !reg_rd_in |=> (reg_rdata_out == PDM_RDATA_IDLE);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle"); // [RL6]

    property p_word_read;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (reg_rd_in && reg_word_in && reg_addr_in == PDM_ADDR_SEL_LOW)
        |=> (reg_rdata_out == {$past(pin_drive_select_high_r), $past(pin_drive_select_low_r)});
    endproperty
    a_word_read: assert property (p_word_read) else $error("word read wrong"); // [RL9]

    property p_high_write;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (reg_wr_in && reg_addr_in == PDM_ADDR_SEL_HIGH)
        |=> (pin_drive_select_high_r == $past(reg_wdata_in[7:0])
             && $stable(pin_drive_select_low_r));
    endproperty
    a_high_write: assert property (p_high_write) else $error("high write wrong"); // [RL6]

    sequence s_unmapped_wr;
        reg_wr_in && reg_addr_in != PDM_ADDR_DATA && reg_addr_in != PDM_ADDR_DIR
        && reg_addr_in != PDM_ADDR_SEL_LOW && reg_addr_in != PDM_ADDR_SEL_HIGH;
    endsequence

    property p_unmapped_write;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        s_unmapped_wr |=> ($stable(pin_drive_select_low_r)
                           && $stable(pin_drive_select_high_r)
                           && $stable(port_direction_register_r)
                           && $stable(port_data_register_r));
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write"); // [RL6]

    // No disable here, so the first edge after release is still watched
    property p_reset_state;
        @(posedge ref_clk_in)
        $rose(reset_n_in) |-> (port_direction_register_r == PDM_DIR_OUTPUT
                               && pin_drive_select_low_r == PDM_RESET_BYTE
                               && pin_drive_select_high_r == PDM_RESET_BYTE);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong"); // [RL8]

    property p_data_back;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (reg_rd_in && reg_addr_in == PDM_ADDR_DATA && !port_direction_register_r[0])
        |=> (reg_rdata_out[0] == $past(port_data_register_r[0]));
    endproperty
    a_data_back: assert property (p_data_back) else $error("data bit not read"); // [RL7]

endmodule : pdm_port_drive

// ===== verif/pdm_board.sv
/*
  Board model for the eight port pins: resolves each pin level from the port's pad
  controls, an optional external source and the pull resistors.
  Assumes a driving port wins over the board source; a pin nobody holds toggles.
*/
`timescale 1ns/100ps
module pdm_board
    import pdm_pkg::*;
(
    // Clock
    input  wire logic                clk_in,
    // Pad controls from the port
    input  wire logic [PDM_PINS-1:0] pin_out_in,
    input  wire logic [PDM_PINS-1:0] pin_oe_n_in,
    input  wire logic [PDM_PINS-1:0] pull_up_in,
    input  wire logic [PDM_PINS-1:0] pull_down_in,
    // External source
    input  wire logic [PDM_PINS-1:0] ext_en_in,
    input  wire logic [PDM_PINS-1:0] ext_val_in,
    // Resolved level
    output logic      [PDM_PINS-1:0] level_out
);
    logic [PDM_PINS-1:0] float_r = '0;

    // Floating pin shows the inverse of its last level, never a stale value
    always @(posedge clk_in)
    begin
        float_r <= ~level_out;
    end

    always_comb
    begin
        for (int i = 0; i < PDM_PINS; i++)
        begin
            if (!pin_oe_n_in[i])
                level_out[i] = pin_out_in[i];
            else if (ext_en_in[i])
                level_out[i] = ext_val_in[i];
            else if (pull_up_in[i])
                level_out[i] = 1'b1;
            else if (pull_down_in[i])
                level_out[i] = 1'b0;
            else
                level_out[i] = float_r[i];
        end
    end
endmodule : pdm_board

// ===== verif/pdm_port_drive_bench.sv
/*
  Self-checking bench for the port drive mode block with a board model on the pins.
  Assumes byte reads return the register in the low byte of the read data.
*/
`timescale 1ns/100ps
module pdm_port_drive_bench
    import pdm_pkg::*;
;
    typedef struct packed {
        logic       dir;
        logic [1:0] code;
        logic       data;
        logic       pout;
        logic       oe_n;
        logic       pu;
        logic       pd;
    } pdm_row_s;

    // Output rows at index code*2+data, input rows at 8+code
    localparam pdm_row_s ROWS [12] = '{
        '{1'b0, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}, '{1'b0, 2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0},
        '{1'b0, 2'h1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0}, '{1'b0, 2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
        '{1'b0, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0}, '{1'b0, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0},
        '{1'b0, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0}, '{1'b0, 2'h3, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
        '{1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}, '{1'b1, 2'h1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1},
        '{1'b1, 2'h2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0}, '{1'b1, 2'h3, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}
    };
    localparam logic [15:0] MIX_SEL = 16'h3355;

    logic        ref_clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [15:0] reg_addr   = 16'h0000;
    logic [15:0] reg_wdata  = 16'h0000;
    logic        reg_word   = 1'b0;
    logic        reg_wr     = 1'b0;
    logic        reg_rd     = 1'b0;
    logic [15:0] reg_rdata;
    logic [7:0]  pin_lvl, pin_o, pin_oe_n, pull_up, pull_down;
    logic [7:0]  ext_en     = 8'h00;
    logic [7:0]  ext_val    = 8'h00;
    logic [15:0] rd;
    logic [7:0]  e_o, e_oe, e_pu, e_pd, msk;
    int          err_total  = 0;
    int          cmp_count  = 0;
    int          cyc        = 0;
    int          ix;

    pdm_port_drive u_dut (
        .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_word_in(reg_word), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .pin_in(pin_lvl), .pin_out(pin_o),
        .pin_oe_n_out(pin_oe_n), .pull_up_out(pull_up), .pull_down_out(pull_down));

    pdm_board u_board (
        .clk_in(ref_clk_in), .pin_out_in(pin_o), .pin_oe_n_in(pin_oe_n),
        .pull_up_in(pull_up), .pull_down_in(pull_down), .ext_en_in(ext_en),
        .ext_val_in(ext_val), .level_out(pin_lvl));

    always #12.5 ref_clk_in = ~ref_clk_in;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic finish_test;
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    always @(posedge ref_clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_total++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [7:0] exp_v, input logic [7:0] got_v);
        cmp_count++;
        if (got_v !== exp_v)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp_v, got_v);
            err_total++;
        end
    endtask : check

    task automatic check_word(input string what, input logic [15:0] exp_v);
        check(what, exp_v[7:0], rd[7:0]);
        check(what, exp_v[15:8], rd[15:8]);
    endtask : check_word

    task automatic reg_write(input logic [15:0] a, input logic [15:0] d, input logic w);
        @(posedge ref_clk_in);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_word  <= w;
        reg_wr    <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr    <= 1'b0;
    endtask : reg_write

    // Read data stand only in the cycle after the strobe edge
    task automatic reg_read(input logic [15:0] a, input logic w);
        @(posedge ref_clk_in);
        reg_addr <= a;
        reg_word <= w;
        reg_rd   <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd   <= 1'b0;
        #1 rd = reg_rdata;
    endtask : reg_read

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : settle

    task automatic do_reset;
        reset_n_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
    endtask : do_reset

    task automatic check_reset;
        check("oe_n", 8'hFF, pin_oe_n);
        check("pulls", 8'h00, pull_up | pull_down);
        reg_read(PDM_ADDR_SEL_LOW, 1'b1);
        check_word("sel_word", 16'h0000);
        reg_read(PDM_ADDR_DIR, 1'b0);
        check("dir", PDM_DIR_OUTPUT, rd[7:0]);
    endtask : check_reset

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        do_reset();
        check_reset();
        for (int r = 0; r < 12; r++)
        begin
            reg_write(PDM_ADDR_DATA, {8'h00, {8{ROWS[r].data}}}, 1'b0);
            reg_write(PDM_ADDR_DIR, {8'h00, {8{ROWS[r].dir}}}, 1'b0);
            reg_write(PDM_ADDR_SEL_LOW, {8'h00, {8{ROWS[r].code[0]}}}, 1'b0);
            reg_write(PDM_ADDR_SEL_HIGH, {8'h00, {8{ROWS[r].code[1]}}}, 1'b0);
            settle(2);
            check("oe_n", {8{ROWS[r].oe_n}}, pin_oe_n);
            check("pull_up", {8{ROWS[r].pu}}, pull_up);
            check("pull_down", {8{ROWS[r].pd}}, pull_down);
            if (!ROWS[r].dir)
                check("pin_out", {8{ROWS[r].pout}}, pin_o);
        end
        // Mixed codes from one word write, mixed directions from a byte write
        reg_write(PDM_ADDR_DATA, 16'h00FF, 1'b0);
        reg_write(PDM_ADDR_DIR, 16'h00F0, 1'b0);
        reg_write(PDM_ADDR_SEL_LOW, 16'h3355, 1'b1);
        settle(2);
        for (int n = 0; n < 8; n++)
        begin
            ix = (n < 4) ? 4 * MIX_SEL[8+n] + 2 * MIX_SEL[n] + 1
                         : 8 + 2 * MIX_SEL[8+n] + MIX_SEL[n];
            e_o[n]  = ROWS[ix].pout;
            e_oe[n] = ROWS[ix].oe_n;
            e_pu[n] = ROWS[ix].pu;
            e_pd[n] = ROWS[ix].pd;
        end
        msk = 8'h0F;
        check("mix_oe_n", e_oe, pin_oe_n);
        check("mix_pin_out", e_o & msk, pin_o & msk);
        check("mix_pu", e_pu, pull_up);
        check("mix_pd", e_pd, pull_down);
        reg_read(PDM_ADDR_SEL_LOW, 1'b1);
        check_word("sel_word", 16'h3355);
        reg_read(PDM_ADDR_SEL_HIGH, 1'b0);
        check("sel_high", 8'h33, rd[7:0]);
        settle(1);
        rd = reg_rdata;
        check_word("rdata_gone", PDM_RDATA_IDLE);
        // Output pins read the stored bit, pulled input pins 5 and 6 their pulled level
        reg_read(PDM_ADDR_DATA, 1'b0);
        check("mix_data", 8'h2F, rd[7:0] & 8'h6F);
        // Byte writes touch one register only
        reg_write(PDM_ADDR_SEL_LOW, 16'hAAC3, 1'b0);
        reg_write(PDM_ADDR_SEL_HIGH, 16'h005A, 1'b0);
        reg_write(16'hF25E, 16'hFFFF, 1'b1);
        reg_read(PDM_ADDR_SEL_LOW, 1'b1);
        check_word("sel_bytes", 16'h5AC3);
        reg_read(16'hF25E, 1'b1);
        check_word("unmapped", 16'h0000);
        // Input mode reads the live pin level
        ext_en  <= 8'hFF;
        ext_val <= 8'hA6;
        reg_write(PDM_ADDR_DIR, 16'h00FF, 1'b0);
        reg_write(PDM_ADDR_SEL_LOW, 16'h0000, 1'b1);
        settle(5);
        reg_read(PDM_ADDR_DATA, 1'b0);
        check("pin_read", 8'hA6, rd[7:0]);
        ext_en <= 8'h00;
        reg_write(PDM_ADDR_SEL_HIGH, 16'h00FF, 1'b0);
        settle(5);
        reg_read(PDM_ADDR_DATA, 1'b0);
        check("pull_up_read", 8'hFF, rd[7:0]);
        reg_write(PDM_ADDR_SEL_LOW, 16'h00FF, 1'b1);
        settle(5);
        reg_read(PDM_ADDR_DATA, 1'b0);
        check("pull_down_read", 8'h00, rd[7:0]);
        // Second reset in mid-run
        @(posedge ref_clk_in);
        do_reset();
        check_reset();
        finish_test();
    end
endmodule : pdm_port_drive_bench
